//--- design/sar_adc_pkg.sv
package sar_adc_pkg;
    // register byte offsets
    localparam logic [7:0] ctrl0_off      = 8'h00;
    localparam logic [7:0] ctrl1_off      = 8'h04;
    localparam logic [7:0] res_high_off   = 8'h08;
    localparam logic [7:0] res_low_off    = 8'h0c;
    localparam logic [7:0] flag_off       = 8'h10;
    localparam logic [7:0] enable_off     = 8'h14;
    localparam logic [7:0] sleep_off      = 8'h18;
    // control zero, control one and flag fields
    localparam int justify_bit     = 7;
    localparam int ref_bit         = 6;
    localparam int chan_lsb        = 2;
    localparam int status_bit      = 1;
    localparam int power_bit       = 0;
    localparam int clksel_lsb      = 4;
    localparam int done_flag_bit   = 6;
    localparam logic [7:0] ctrl_reset = 8'h00;
    // timing
    localparam int result_bits     = 10;
    localparam int conv_periods    = 11;
    localparam int abort_periods   = 2;
    localparam int clk_mhz         = 200;
    localparam int settle_ns       = 5;
    localparam int settle_cycles   = (settle_ns * clk_mhz + 999) / 1000;
    // clock select codes
    localparam logic [2:0] div2_code  = 3'h0;
    localparam logic [2:0] div4_code  = 3'h4;
    localparam logic [2:0] div8_code  = 3'h1;
    localparam logic [2:0] div16_code = 3'h5;
    localparam logic [2:0] div32_code = 3'h2;
    localparam logic [2:0] div64_code = 3'h6;

    typedef enum logic [3:0] {
        st_idle  = 4'h1,
        st_conv  = 4'h2,
        st_abort = 4'h4,
        st_wait  = 4'h8
    } seq_state_t;

    typedef struct packed {
        logic       justify;
        logic       ref_sel;
        logic [3:0] channel;
        logic       status;
        logic       power;
    } ctrl0_t;
endpackage : sar_adc_pkg

//--- design/sar_bit_timer.sv
`timescale 1ns/1ps
module sar_bit_timer
(
    input  wire logic       clk,        // system clock
    input  wire logic       reset,      // sync reset
    input  wire logic       ce,         // clock enable
    input  wire logic [2:0] sel,        // conversion clock select
    input  wire logic       osc_tick,   // dedicated oscillator edge, synchronised
    input  wire logic       restart,    // restart the period
    output logic            tick        // one pulse per bit period
);
    logic [5:0] cnt_reg;
    logic [5:0] limit;
    wire        use_osc = (sel[1:0] == 2'b11);

    function automatic logic [5:0] div_limit(input logic [2:0] s);
        case (s)
            sar_adc_pkg::div2_code:  div_limit = 6'h01;
            sar_adc_pkg::div4_code:  div_limit = 6'h03;
            sar_adc_pkg::div8_code:  div_limit = 6'h07;
            sar_adc_pkg::div16_code: div_limit = 6'h0f;
            sar_adc_pkg::div32_code: div_limit = 6'h1f;
            sar_adc_pkg::div64_code: div_limit = 6'h3f;
            default:                 div_limit = 6'h01;
        endcase
    endfunction : div_limit

    assign limit = div_limit(sel);
    // system clock divided unless the oscillator is chosen  [RL5] [RL7]
    assign tick  = ce && !restart && (use_osc ? osc_tick : (cnt_reg >= limit));

    always_ff @(posedge clk)
    begin
        if (reset || restart)
            cnt_reg <= 6'h00;
        else if (ce)
            cnt_reg <= tick ? 6'h00 : (use_osc ? 6'h00 : cnt_reg + 6'h01);
    end
endmodule : sar_bit_timer

//--- design/sar_adc_control.sv
// Functional notes
// [RL1] a conversion yields a 10-bit result written to both result registers
// [RL2] channel field picks the one input feeding the sample-and-hold
// [RL3] software waits a settling time after changing channel
// [RL4] reference bit picks supply or external pin; negative is ground
// [RL5] three-bit select gives six system clock dividers or the oscillator
// [RL6] one bit period per bit; eleven periods per conversion
// [RL7] divider choices follow the system clock frequency
// [RL8] software uses the oscillator above 1 MHz only for sleep conversions
// [RL9] done flag set at every conversion end regardless of enable
// [RL10] software clears the done flag; hardware never clears it
// [RL11] interrupt gated by its enable, active running or sleeping
// [RL12] interrupt during sleep wakes the device
// [RL13] justify bit picks left or right result alignment
// [RL14] power bit enables; start bit set in a later write
// [RL15] completion clears status, sets flag, loads result
// [RL16] early clear aborts, keeps result, waits two periods, reacquires
// [RL17] left: high holds 9..2, low top holds 1..0; right: high low bits 9..8
// [RL18] oscillator start and completion cross domains through synchronisers
// [RL19] one bit per period, msb first, trial register, one compare each
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module sar_adc_control
(
    input  wire logic        clk,           // system clock, 200 MHz
    input  wire logic        reset,         // synchronous reset, active high
    input  wire logic        ce,            // clock enable
    input  wire logic        osc_clk_in,    // dedicated oscillator level
    input  wire logic        comp_in,       // comparator: input above trial
    input  wire logic        sleeping,      // device in sleep
    output logic [3:0]       channel_select,// mux select to sample-and-hold
    output logic             reference_select, // positive reference choice
    output logic [9:0]       trial_code,    // trial word to the dac
    output logic             sample,        // sample-and-hold tracking
    output logic             irq,           // interrupt level
    output logic             wake,          // wake request
    input  wire logic        s_axi_awvalid, // write address valid
    output logic             s_axi_awready, // write address ready
    input  wire logic [7:0]  s_axi_awaddr,  // write address
    input  wire logic        s_axi_wvalid,  // write data valid
    output logic             s_axi_wready,  // write data ready
    input  wire logic [31:0] s_axi_wdata,   // write data
    input  wire logic [3:0]  s_axi_wstrb,   // write strobes
    output logic             s_axi_bvalid,  // write response valid
    input  wire logic        s_axi_bready,  // write response ready
    output logic [1:0]       s_axi_bresp,   // write response
    input  wire logic        s_axi_arvalid, // read address valid
    output logic             s_axi_arready, // read address ready
    input  wire logic [7:0]  s_axi_araddr,  // read address
    output logic             s_axi_rvalid,  // read data valid
    input  wire logic        s_axi_rready,  // read data ready
    output logic [31:0]      s_axi_rdata,   // read data
    output logic [1:0]       s_axi_rresp    // read response
);
    sar_adc_pkg::ctrl0_t     ctrl0_reg;
    logic [2:0]              clksel_reg;
    logic [7:0]              res_high_reg;
    logic [7:0]              res_low_reg;
    logic                    flag_reg;
    logic                    enable_reg;
    logic                    sleep_off_reg;
    logic [9:0]              trial_reg;
    logic [9:0]              result_reg;
    logic [3:0]              step_reg;
    sar_adc_pkg::seq_state_t state_reg;
    sar_adc_pkg::seq_state_t state_next;

    // axi write side
    logic        aw_hold_reg;
    logic        w_hold_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        ar_busy_reg;
    wire         aw_take = s_axi_awvalid && !aw_hold_reg && !s_axi_bvalid;
    wire         w_take  = s_axi_wvalid && !w_hold_reg && !s_axi_bvalid;
    wire         have_aw = aw_hold_reg || aw_take;
    wire         have_w  = w_hold_reg || w_take;
    wire         do_wr   = have_aw && have_w && ce;
    wire [7:0]   wr_addr = aw_hold_reg ? aw_addr_reg : s_axi_awaddr;
    wire [31:0]  wr_data = w_hold_reg ? w_data_reg : s_axi_wdata;
    wire [3:0]   wr_strb = w_hold_reg ? w_strb_reg : s_axi_wstrb;
    wire         wr_lane = wr_strb[0];
    wire [7:0]   wr_byte = wr_data[7:0];

    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a == sar_adc_pkg::ctrl0_off) || (a == sar_adc_pkg::ctrl1_off)
                  || (a == sar_adc_pkg::res_high_off) || (a == sar_adc_pkg::res_low_off)
                  || (a == sar_adc_pkg::flag_off) || (a == sar_adc_pkg::enable_off)
                  || (a == sar_adc_pkg::sleep_off);
    endfunction : known_addr

    wire wr_ctrl0  = do_wr && wr_lane && wr_addr == sar_adc_pkg::ctrl0_off;
    wire wr_ctrl1  = do_wr && wr_lane && wr_addr == sar_adc_pkg::ctrl1_off;
    wire wr_flag   = do_wr && wr_lane && wr_addr == sar_adc_pkg::flag_off;
    wire wr_enable = do_wr && wr_lane && wr_addr == sar_adc_pkg::enable_off;
    wire wr_sleep  = do_wr && wr_lane && wr_addr == sar_adc_pkg::sleep_off;
    wire [7:0] new_ctrl0 = wr_byte;

    assign s_axi_awready = ce && !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready  = ce && !w_hold_reg && !s_axi_bvalid;
    assign s_axi_arready = ce && !ar_busy_reg;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            aw_addr_reg  <= 8'h00;
            w_data_reg   <= 32'h0000_0000;
            w_strb_reg   <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end
        else if (ce)
        begin
            if (do_wr)
            begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= known_addr(wr_addr) ? 2'h0 : 2'h2;
            end
            else
            begin
                if (aw_take)
                begin
                    aw_hold_reg <= 1'b1;
                    aw_addr_reg <= s_axi_awaddr;
                end
                if (w_take)
                begin
                    w_hold_reg <= 1'b1;
                    w_data_reg <= s_axi_wdata;
                    w_strb_reg <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready)
                    s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi read side
    logic [7:0] rd_byte;
    always_comb
    begin
        case (s_axi_araddr)
            sar_adc_pkg::ctrl0_off:    rd_byte = ctrl0_reg;
            sar_adc_pkg::ctrl1_off:    rd_byte = {1'b0, clksel_reg, 4'h0};
            sar_adc_pkg::res_high_off: rd_byte = res_high_reg;
            sar_adc_pkg::res_low_off:  rd_byte = res_low_reg;
            sar_adc_pkg::flag_off:     rd_byte = {1'b0, flag_reg, 6'h00};
            sar_adc_pkg::enable_off:   rd_byte = {1'b0, enable_reg, 6'h00};
            sar_adc_pkg::sleep_off:    rd_byte = {7'h00, sleep_off_reg};
            default:                   rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ar_busy_reg  <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && !ar_busy_reg)
            begin
                ar_busy_reg  <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_byte};
                s_axi_rresp  <= known_addr(s_axi_araddr) ? 2'h0 : 2'h2;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                ar_busy_reg  <= 1'b0;
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // oscillator crossing: two flops then edge detect on the second  [RL18]
    logic osc_meta_reg;
    logic osc_sync_reg;
    logic osc_prev_reg;
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end
        else if (ce)
        begin
            osc_meta_reg <= osc_clk_in;
            osc_sync_reg <= osc_meta_reg;
            osc_prev_reg <= osc_sync_reg;
        end
    end
    wire osc_tick = osc_sync_reg && !osc_prev_reg;

    logic tick;
    wire  restart = (state_reg == sar_adc_pkg::st_idle);
    sar_bit_timer u_timer
    (
        .clk      (clk),
        .reset    (reset),
        .ce       (ce),
        .sel      (clksel_reg),
        .osc_tick (osc_tick),
        .restart  (restart),
        .tick     (tick)
    );

    // conversion sequencer
    wire powered    = ctrl0_reg.power && !sleep_off_reg;
    wire go_set     = wr_ctrl0 && new_ctrl0[sar_adc_pkg::status_bit]
                   && ctrl0_reg.power;                                   // [RL14]
    wire user_abort = wr_ctrl0 && !new_ctrl0[sar_adc_pkg::status_bit]
                   && state_reg == sar_adc_pkg::st_conv;                 // [RL16]
    wire sleep_abort = sleeping && clksel_reg[1:0] != 2'b11
                   && state_reg == sar_adc_pkg::st_conv;
    wire last_step  = tick && step_reg == 4'(sar_adc_pkg::conv_periods - 1); // [RL6]
    wire done_evt   = state_reg == sar_adc_pkg::st_conv && state_next == sar_adc_pkg::st_idle;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            sar_adc_pkg::st_idle:
                if (go_set && powered)
                    state_next = sar_adc_pkg::st_conv;
            sar_adc_pkg::st_conv:
                if (user_abort || sleep_abort || !powered)
                    state_next = sar_adc_pkg::st_abort;
                else if (last_step)
                    state_next = sar_adc_pkg::st_idle;
            sar_adc_pkg::st_abort:
                if (tick && step_reg == 4'(sar_adc_pkg::abort_periods - 1))   // [RL16]
                    state_next = sar_adc_pkg::st_idle;
            default:
                state_next = sar_adc_pkg::st_idle;
        endcase
    end

    // trial bit: period 0 holds, periods 1..10 resolve msb first  [RL19]
    wire [3:0] bit_idx = 4'(sar_adc_pkg::result_bits) - step_reg;
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg <= sar_adc_pkg::st_idle;
            step_reg  <= 4'h0;
            trial_reg <= 10'h000;
        end
        else if (ce)
        begin
            state_reg <= state_next;
            if (state_next != state_reg)
                step_reg <= 4'h0;
            else if (tick)
                step_reg <= step_reg + 4'h1;
            if (state_reg == sar_adc_pkg::st_idle)
                trial_reg <= 10'h200;
            else if (state_reg == sar_adc_pkg::st_conv && tick && step_reg != 4'h0)
            begin
                if (!comp_in)
                    trial_reg[bit_idx] <= 1'b0;                                // [RL19]
                if (bit_idx != 4'h0)
                    trial_reg[bit_idx - 4'h1] <= 1'b1;
            end
        end
    end

    // final word including last compare  [RL1]
    always_comb
    begin
        result_reg = trial_reg;
        if (!comp_in)
            result_reg[0] = 1'b0;
    end

    // registers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ctrl0_reg     <= sar_adc_pkg::ctrl_reset;
            clksel_reg    <= 3'h0;
            res_high_reg  <= 8'h00;
            res_low_reg   <= 8'h00;
            flag_reg      <= 1'b0;
            enable_reg    <= 1'b0;
            sleep_off_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_ctrl0)
            begin
                ctrl0_reg        <= new_ctrl0;
                ctrl0_reg.status <= go_set && powered;                       // [RL14]
            end
            if (done_evt || state_next == sar_adc_pkg::st_abort)
                ctrl0_reg.status <= 1'b0;                                    // [RL15]
            if (wr_ctrl1)
                clksel_reg <= wr_byte[sar_adc_pkg::clksel_lsb +: 3];
            if (wr_enable)
                enable_reg <= wr_byte[sar_adc_pkg::done_flag_bit];
            // oscillator sleep conversion without irq powers down after  [RL11]
            if (done_evt && sleeping && !enable_reg)
                sleep_off_reg <= 1'b1;
            else if (wr_sleep && wr_byte[0])
                sleep_off_reg <= 1'b0;
            // write one clears; a new completion wins  [RL10]
            if (done_evt)
                flag_reg <= 1'b1;                                            // [RL9]
            else if (wr_flag && wr_byte[sar_adc_pkg::done_flag_bit])
                flag_reg <= 1'b0;
            if (done_evt)                                                    // [RL15]
            begin
                if (ctrl0_reg.justify)
                begin
                    res_high_reg <= {6'h00, result_reg[9:8]};                // [RL17]
                    res_low_reg  <= result_reg[7:0];
                end
                else
                begin
                    res_high_reg <= result_reg[9:2];                         // [RL13]
                    res_low_reg  <= {result_reg[1:0], 6'h00};
                end
            end
        end
    end

    assign channel_select   = ctrl0_reg.channel;                             // [RL2]
    assign reference_select = ctrl0_reg.ref_sel;                             // [RL4]
    assign trial_code       = trial_reg;
    assign sample           = powered && state_reg == sar_adc_pkg::st_idle;  // [RL16]
    assign irq              = flag_reg && enable_reg;                        // [RL11]
    assign wake             = irq && sleeping;                               // [RL12]
endmodule : sar_adc_control

//--- tb/analog_front_model.sv
`timescale 1ns/1ps
module analog_front_model
(
    input  wire logic       clk,              // system clock
    input  wire logic [3:0] channel_select,   // routed input
    input  wire logic       reference_select, // positive reference choice
    input  wire logic [9:0] trial_code,       // trial word
    input  wire logic       sample,           // hold tracking
    output logic            comp_in           // held input above trial
);
    logic [9:0] held_reg;
    wire  [9:0] level = 10'h1b3 + 10'h053 * {6'h00, channel_select};

    always_ff @(posedge clk)
    begin
        if (sample)
        begin
            held_reg <= reference_select ? ~level : level;
        end
    end
    // half an lsb above the held level, so no trial ever ties
    assign comp_in = {held_reg, 1'b1} > {trial_code, 1'b0};
endmodule : analog_front_model

//--- tb/sar_adc_control_properties.sv
`timescale 1ns/1ps
module sar_adc_control_properties
(
    input wire logic        clk,           // system clock
    input wire logic        reset,         // sync reset
    input wire logic        sleeping,      // device in sleep
    input wire logic        sample,        // hold tracking
    input wire logic        irq,           // interrupt level
    input wire logic        wake,          // wake request
    input wire logic        s_axi_awvalid, // write address valid
    input wire logic        s_axi_awready, // write address ready
    input wire logic        s_axi_wvalid,  // write data valid
    input wire logic        s_axi_wready,  // write data ready
    input wire logic        s_axi_bvalid,  // write response valid
    input wire logic        s_axi_bready,  // write response ready
    input wire logic [1:0]  s_axi_bresp,   // write response
    input wire logic        s_axi_arvalid, // read address valid
    input wire logic        s_axi_arready, // read address ready
    input wire logic        s_axi_rvalid,  // read data valid
    input wire logic        s_axi_rready,  // read data ready
    input wire logic [31:0] s_axi_rdata    // read data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence conv_begin;
        $fell(sample);
    endsequence

    a_wake_level: assert property (wake == (irq && sleeping))
        else $error("wake differs from irq during sleep");
    a_irq_fall_cause: assert property ($fell(irq) |-> $past(s_axi_wvalid))
        else $error("irq dropped without a register write");
    a_conv_span: assert property (conv_begin |-> !sample [*8])
        else $error("hold tracking again too early");
    a_write_answer: assert property (write_taken |=> s_axi_bvalid)
        else $error("write response late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    a_single_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_single_read: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
endmodule : sar_adc_control_properties

bind sar_adc_control sar_adc_control_properties u_sar_adc_control_properties
(
    .clk(clk), .reset(reset), .sleeping(sleeping), .sample(sample), .irq(irq), .wake(wake),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata)
);

//--- tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
    logic        clk = 1'b0, reset = 1'b1, ce = 1'b1;
    logic        osc = 1'b0, sleeping = 1'b0;
    logic        comp_in, sample, irq, wake, ref_sel;
    logic [3:0]  chan;
    logic [9:0]  trial;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, resp;
    int          miscompares = 0, n_tests = 0, low_cnt = 0;

    always #2.5 clk = ~clk;
    always #18.5 osc = ~osc;
    always @(posedge clk) if (!sample) low_cnt <= low_cnt + 1;

    sar_adc_control u_sar_adc_control
    (
        .clk(clk), .reset(reset), .ce(ce), .osc_clk_in(osc), .comp_in(comp_in),
        .sleeping(sleeping), .channel_select(chan), .reference_select(ref_sel),
        .trial_code(trial), .sample(sample), .irq(irq), .wake(wake),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp)
    );
    analog_front_model u_analog_front_model
    (
        .clk(clk), .channel_select(chan), .reference_select(ref_sel),
        .trial_code(trial), .sample(sample), .comp_in(comp_in)
    );

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end
        while (!rvalid);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rd_reg

    // divider per select code: 000,100,001,101,010,110 -> 2..64
    function automatic int div_of(input logic [2:0] c);
        return 2 << {c[1:0], c[2]};
    endfunction : div_of

    task automatic t_reset;
        rd_reg(sar_adc_pkg::ctrl0_off);
        `CHK(rd, 32'h0)
        rd_reg(sar_adc_pkg::flag_off);
        `CHK(rd, 32'h0)
        `CHK(sample, 1'b0)
        wr(sar_adc_pkg::ctrl0_off, 32'h3);
        rd_reg(sar_adc_pkg::ctrl0_off);
        `CHK(rd, 32'h1)
        $display("test reset done");
    endtask : t_reset

    task automatic t_convert(input logic [2:0] code, input logic [3:0] ch,
                             input logic rf, input logic jf);
        int c0;
        logic [9:0] v;
        v = 10'h1b3 + 10'h053 * {6'h00, ch};
        if (rf) v = ~v;
        wr(sar_adc_pkg::ctrl1_off, {25'h0, code, 4'h0});
        wr(sar_adc_pkg::ctrl0_off, {24'h0, jf, rf, ch, 2'b01});
        wr(sar_adc_pkg::flag_off, 32'h40);
        `CHK(chan, ch)
        `CHK(ref_sel, rf)
        repeat (sar_adc_pkg::settle_cycles + 2) @(posedge clk);
        c0 = low_cnt;
        wr(sar_adc_pkg::ctrl0_off, {24'h0, jf, rf, ch, 2'b11});
        do rd_reg(sar_adc_pkg::ctrl0_off); while (rd[1]);
        if (code[1:0] != 2'b11) `CHK(low_cnt - c0, 11 * div_of(code))
        rd_reg(sar_adc_pkg::res_high_off);
        `CHK(rd[7:0], jf ? {6'h00, v[9:8]} : v[9:2])
        rd_reg(sar_adc_pkg::res_low_off);
        `CHK(rd[7:0], jf ? v[7:0] : {v[1:0], 6'h00})
        rd_reg(sar_adc_pkg::flag_off);
        `CHK(rd[6], 1'b1)
        `CHK(irq, 1'b0)
        $display("test convert code %h done", code);
    endtask : t_convert

    task automatic t_irq;
        wr(sar_adc_pkg::flag_off, 32'h0);
        rd_reg(sar_adc_pkg::flag_off);
        `CHK(rd[6], 1'b1)
        wr(sar_adc_pkg::enable_off, 32'h40);
        `CHK(irq, 1'b1)
        wr(sar_adc_pkg::enable_off, 32'h0);
        `CHK(irq, 1'b0)
        wr(sar_adc_pkg::enable_off, 32'h40);
        wr(sar_adc_pkg::flag_off, 32'h40);
        `CHK(irq, 1'b0)
        $display("test irq done");
    endtask : t_irq

    task automatic t_abort;
        logic [7:0] hi, lo;
        rd_reg(sar_adc_pkg::res_high_off);
        hi = rd[7:0];
        rd_reg(sar_adc_pkg::res_low_off);
        lo = rd[7:0];
        wr(sar_adc_pkg::ctrl1_off, 32'h10);
        wr(sar_adc_pkg::ctrl0_off, 32'h15);
        repeat (sar_adc_pkg::settle_cycles + 2) @(posedge clk);
        wr(sar_adc_pkg::ctrl0_off, 32'h17);
        ce <= 1'b0;
        repeat (100) @(posedge clk);
        `CHK(sample, 1'b0)
        ce <= 1'b1;
        wr(sar_adc_pkg::ctrl0_off, 32'h15);
        `CHK(sample, 1'b0)
        for (int i = 0; i < 100 && sample !== 1'b1; i++) @(posedge clk);
        `CHK(sample, 1'b1)
        rd_reg(sar_adc_pkg::res_high_off);
        `CHK(rd[7:0], hi)
        rd_reg(sar_adc_pkg::res_low_off);
        `CHK(rd[7:0], lo)
        $display("test abort done");
    endtask : t_abort

    task automatic t_sleep;
        // oscillator clock chosen for the sleeping conversion, as for select codes 3 and 7 in t_convert
        wr(sar_adc_pkg::ctrl1_off, 32'h30);
        @(posedge clk);
        sleeping <= 1'b1;
        wr(sar_adc_pkg::ctrl0_off, 32'h03);
        for (int i = 0; i < 400 && wake !== 1'b1; i++) @(posedge clk);
        `CHK(wake, 1'b1)
        `CHK(irq, 1'b1)
        sleeping <= 1'b0;
        @(posedge clk);
        `CHK(wake, 1'b0)
        wr(sar_adc_pkg::flag_off, 32'h40);
        $display("test sleep done");
    endtask : t_sleep

    task automatic t_bus;
        rd_reg(8'h1c);
        `CHK(resp, 2'h2)
        `CHK(rd, 32'h0)
        wr(8'h1c, 32'hff);
        `CHK(resp, 2'h2)
        rd_reg(sar_adc_pkg::res_high_off);
        wr(sar_adc_pkg::res_high_off, ~rd);
        rd_reg(sar_adc_pkg::res_high_off);
        `CHK(rd, ~wdata)
        $display("test bus done");
    endtask : t_bus

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        for (int c = 0; c < 8; c++) t_convert(3'(c), 4'(c), c[1], c[0]);
        t_irq();
        t_abort();
        t_sleep();
        t_bus();
        complete_run();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        complete_run();
    end
endmodule : tb_top
